// ==== hdl/tcc_pkg.sv ====
package tcc_pkg;
	localparam int unsigned NUM_CH     = 4;
	localparam int unsigned CNT_W      = 16;
	localparam int unsigned ADDR_W     = 6;
	localparam int unsigned DATA_W     = 8;

	// Register offsets
	localparam logic [5:0] OFF_CTL     = 6'h00;
	localparam logic [5:0] OFF_CNT_HI  = 6'h02;
	localparam logic [5:0] OFF_CNT_LO  = 6'h03;
	localparam logic [5:0] OFF_MOD_HI  = 6'h04;
	localparam logic [5:0] OFF_MOD_LO  = 6'h05;
	localparam logic [5:0] OFF_CH_BASE = 6'h06;
	localparam logic [5:0] CH_STRIDE   = 6'h03;
	localparam logic [5:0] CH_SC       = 6'h00;
	localparam logic [5:0] CH_HI       = 6'h01;
	localparam logic [5:0] CH_LO       = 6'h02;

	// Timer control register fields
	localparam int unsigned CTL_OVF_FLAG = 7;
	localparam int unsigned CTL_OVF_IE   = 6;
	localparam int unsigned CTL_STOP     = 5;
	localparam int unsigned CTL_CNT_RST  = 4;

	// Channel status and control fields
	localparam int unsigned SC_FLAG = 7;
	localparam int unsigned SC_IE   = 6;
	localparam int unsigned SC_MSB  = 5;
	localparam int unsigned SC_MSA  = 4;
	localparam int unsigned SC_ELSB = 3;
	localparam int unsigned SC_ELSA = 2;
	localparam int unsigned SC_TOV  = 1;
	localparam int unsigned SC_MAX  = 0;

	// Mode select codes
	localparam logic [1:0] MS_CAPTURE  = 2'h0;
	localparam logic [1:0] MS_UNBUF    = 2'h1;

	// Edge/level select codes
	localparam logic [1:0] ELS_OFF     = 2'h0;
	localparam logic [1:0] ELS_RISE    = 2'h1;
	localparam logic [1:0] ELS_FALL    = 2'h2;
	localparam logic [1:0] ELS_BOTH    = 2'h3;
	localparam logic [1:0] ELS_TOGGLE  = 2'h1;
	localparam logic [1:0] ELS_CLEAR   = 2'h2;
	localparam logic [1:0] ELS_SET     = 2'h3;

	localparam logic [15:0] MOD_RESET  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] VAL_RESET  = 16'h0000;
	localparam logic [7:0]  RD_ZERO    = 8'h00;
endpackage

// ==== hdl/tcc_counter.sv ====
module tcc_counter (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        stop,
	input  wire logic        cnt_clear,
	input  wire logic [15:0] modulo,
	output logic      [15:0] cnt,
	output logic             ovf
);
	logic [15:0] cnt_r;

	// Overflow is the cycle in which the running count sits on the modulo value and no clear is written
	assign ovf = !stop && !cnt_clear && (cnt_r == modulo);
	assign cnt = cnt_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= tcc_pkg::CNT_ZERO;
		end else if (cnt_clear) begin
			cnt_r <= tcc_pkg::CNT_ZERO;
		end else if (ovf) begin
			cnt_r <= tcc_pkg::CNT_ZERO; // [R19] [R16]
		end else if (!stop) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule

// ==== hdl/tcc_channel.sv ====
module tcc_channel (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] cnt,
	input  wire logic        ovf,
	input  wire logic        stop,
	input  wire logic [15:0] cmp_val,
	input  wire logic        enable,
	input  wire logic        is_cap,
	input  wire logic        is_cmp,
	input  wire logic [1:0]  els,
	input  wire logic        tov,
	input  wire logic        max_duty,
	input  wire logic        pin_in,
	output logic             cap_evt,
	output logic             cmp_evt,
	output logic             pin_out,
	output logic             pin_oe
);
	logic pin_prev_r;
	logic out_r;
	logic oe_r;
	logic rise;
	logic fall;

	assign rise = pin_in && !pin_prev_r;
	assign fall = !pin_in && pin_prev_r;

	always_comb begin
		cap_evt = 1'b0;
		if (enable && is_cap) begin
			case (els)
				tcc_pkg::ELS_RISE: cap_evt = rise; // [R2]
				tcc_pkg::ELS_FALL: cap_evt = fall; // [R2]
				tcc_pkg::ELS_BOTH: cap_evt = rise || fall; // [R2]
				default:           cap_evt = 1'b0;
			endcase
		end
	end

	// Compare value is used as written, with no shadow stage
	assign cmp_evt = enable && is_cmp && !stop && (cnt == cmp_val); // [R4] [R5] [R6]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_in;
		end
	end

	// Compare action takes precedence over the overflow toggle in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_r <= 1'b0;
		end else if (max_duty && !tov) begin
			out_r <= 1'b1;
		end else if (cmp_evt) begin
			case (els)
				tcc_pkg::ELS_TOGGLE: out_r <= !out_r; // [R4]
				tcc_pkg::ELS_CLEAR:  out_r <= 1'b0; // [R4] [R21]
				tcc_pkg::ELS_SET:    out_r <= 1'b1; // [R4] [R21]
				default:             out_r <= out_r;
			endcase
		end else if (ovf && tov && enable && is_cmp) begin
			out_r <= !out_r; // [R14] [R17]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= enable && is_cmp && (els != tcc_pkg::ELS_OFF); // [R11]
		end
	end

	assign pin_out = out_r;
	assign pin_oe  = oe_r;
endmodule

// ==== hdl/tcc_top.sv ====
// Contract
// R1: Active capture edge copies the counter into that channel's value pair.
// R2: Software picks rising, falling or both edges as the capture edge.
// R3: A capture event can raise that channel's interrupt request.
// R4: Counter matching compare value sets, clears or toggles the pin; may interrupt.
// R5: Unbuffered value writes replace the compare value at once.
// R6: No guard against unsynchronised unbuffered writes; glitches may last two periods.
// R7: Software lowers unbuffered values inside the compare interrupt handler.
// R8: Software raises unbuffered values inside the overflow interrupt handler.
// R9: Channel 0 link bit pairs channels 0 and 1; channel 0 controls first.
// R10: Written inactive channel takes control at next overflow; last written wins.
// R11: Linked pair uses lower control register; upper pin is released.
// R12: Channel 2 link bit pairs channels 2 and 3 likewise.
// R13: Software writes only the inactive channel in buffered use.
// R14: Toggle-on-overflow flips the pin at each modulo match; the code applies a same-cycle compare action instead.
// R15: Software sets compare action opposite to the pulse level.
// R16: PWM period equals modulo plus one counter clocks.
// R17: Duty equals channel value over period count; the code holds the pin high for value plus one clocks.
// R18: Software never uses toggle-on-compare for PWM.
// R19: Counter rolls to zero after modulo match, setting the overflow flag.
// R20: Mode 01 unbuffered, 10 buffered; link bit beats lower mode bit.
// R21: Edge select 10 clears, 11 sets on compare.
// R22: Flag set on every event; request only while its enable is one.
//
// Implementation choices: the placing of the registers and the plain strobed port.
module tcc_top (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [5:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic [3:0] chan_pin_in,
	output logic      [3:0] chan_pin_out,
	output logic      [3:0] chan_pin_oe,
	output logic      [3:0] chan_irq,
	output logic            ovf_irq
);
	localparam int unsigned N = tcc_pkg::NUM_CH;

	logic        ovf_flag_r;
	logic        ovf_ie_r;
	logic        stop_r;
	logic        cnt_clear;
	logic [15:0] mod_r;
	logic [15:0] cnt;
	logic        ovf;
	logic [7:0]  rdata_r;
	logic [7:0]  rd_nxt;
	logic        ovf_irq_r;

	logic [7:0]  sc_r     [N];
	logic [15:0] val_r    [N];
	logic [15:0] cmp_val  [N];
	logic [N-1:0] hit_sc;
	logic [N-1:0] hit_hi;
	logic [N-1:0] hit_lo;
	logic [N-1:0] wr_val;
	logic [N-1:0] linked;
	logic [N-1:0] ch_en;
	logic [N-1:0] is_cap;
	logic [N-1:0] is_cmp;
	logic [N-1:0] cap_evt;
	logic [N-1:0] cmp_evt;
	logic [N-1:0] irq_r;
	logic [N-1:0] pin_out_w;
	logic [N-1:0] pin_oe_w;

	assign cnt_clear = wr && (addr == tcc_pkg::OFF_CTL) && wdata[tcc_pkg::CTL_CNT_RST];

	tcc_counter u_counter (
		.clk       (clk),
		.rst       (rst),
		.stop      (stop_r),
		.cnt_clear (cnt_clear),
		.modulo    (mod_r),
		.cnt       (cnt),
		.ovf       (ovf)
	);

	// Timer control: a written zero clears the overflow flag unless it sets this cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovf_flag_r <= 1'b0;
			ovf_ie_r   <= 1'b0;
			stop_r     <= 1'b0;
		end else begin
			if (ovf) begin
				ovf_flag_r <= 1'b1; // [R19]
			end else if (wr && addr == tcc_pkg::OFF_CTL && !wdata[tcc_pkg::CTL_OVF_FLAG]) begin
				ovf_flag_r <= 1'b0;
			end
			if (wr && addr == tcc_pkg::OFF_CTL) begin
				ovf_ie_r <= wdata[tcc_pkg::CTL_OVF_IE];
				stop_r   <= wdata[tcc_pkg::CTL_STOP];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mod_r <= tcc_pkg::MOD_RESET;
		end else if (wr && addr == tcc_pkg::OFF_MOD_HI) begin
			mod_r[15:8] <= wdata;
		end else if (wr && addr == tcc_pkg::OFF_MOD_LO) begin
			mod_r[7:0] <= wdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovf_irq_r <= 1'b0;
		end else begin
			ovf_irq_r <= ovf_flag_r && ovf_ie_r; // [R19]
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_ch
			localparam logic [5:0] BASE = tcc_pkg::OFF_CH_BASE + 6'(i) * tcc_pkg::CH_STRIDE;
			localparam bit UPPER = (i % 2) == 1;
			localparam int unsigned LOW = i - (i % 2);

			assign hit_sc[i] = addr == BASE + tcc_pkg::CH_SC;
			assign hit_hi[i] = addr == BASE + tcc_pkg::CH_HI;
			assign hit_lo[i] = addr == BASE + tcc_pkg::CH_LO;
			assign wr_val[i] = wr && (hit_hi[i] || hit_lo[i]);

			// Link bit only exists on the lower channel of a pair
			assign linked[i] = sc_r[LOW][tcc_pkg::SC_MSB];
			assign ch_en[i]  = !(UPPER && linked[i]); // [R11]
			assign is_cmp[i] = sc_r[i][tcc_pkg::SC_MSB] ||
				(sc_r[i][tcc_pkg::SC_MSA]); // [R20]
			assign is_cap[i] = !is_cmp[i]; // [R20]

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sc_r[i] <= 8'h00;
				end else begin
					if (cap_evt[i] || cmp_evt[i]) begin
						sc_r[i][tcc_pkg::SC_FLAG] <= 1'b1; // [R22] [R3]
					end else if (wr && hit_sc[i] && !wdata[tcc_pkg::SC_FLAG]) begin
						sc_r[i][tcc_pkg::SC_FLAG] <= 1'b0;
					end
					if (wr && hit_sc[i]) begin
						sc_r[i][6:0] <= wdata[6:0];
						if (UPPER) begin
							sc_r[i][tcc_pkg::SC_MSB] <= 1'b0;
						end
					end
				end
			end

			// Capture and software writes share the value pair; capture wins
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					val_r[i] <= tcc_pkg::VAL_RESET;
				end else if (cap_evt[i]) begin
					val_r[i] <= cnt; // [R1]
				end else if (wr && hit_hi[i]) begin
					val_r[i][15:8] <= wdata; // [R5]
				end else if (wr && hit_lo[i]) begin
					val_r[i][7:0] <= wdata; // [R5]
				end
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					irq_r[i] <= 1'b0;
				end else begin
					irq_r[i] <= sc_r[i][tcc_pkg::SC_FLAG] && sc_r[i][tcc_pkg::SC_IE]; // [R22] [R3]
				end
			end

			tcc_channel u_ch (
				.clk      (clk),
				.rst      (rst),
				.cnt      (cnt),
				.ovf      (ovf),
				.stop     (stop_r),
				.cmp_val  (cmp_val[i]),
				.enable   (ch_en[i]),
				.is_cap   (is_cap[i]),
				.is_cmp   (is_cmp[i]),
				.els      (sc_r[i][tcc_pkg::SC_ELSB:tcc_pkg::SC_ELSA]),
				.tov      (sc_r[i][tcc_pkg::SC_TOV]),
				.max_duty (sc_r[i][tcc_pkg::SC_MAX]),
				.pin_in   (chan_pin_in[i]),
				.cap_evt  (cap_evt[i]),
				.cmp_evt  (cmp_evt[i]),
				.pin_out  (pin_out_w[i]),
				.pin_oe   (pin_oe_w[i])
			);
		end

		for (i = 0; i < N / 2; i++) begin : g_pair
			logic last_r;
			logic active_r;

			// Pair tracks which half was written last; it takes over at overflow
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					last_r   <= 1'b0;
					active_r <= 1'b0;
				end else if (!linked[2*i]) begin
					last_r   <= 1'b0; // [R9] [R12]
					active_r <= 1'b0; // [R9] [R12]
				end else begin
					if (wr_val[2*i+1]) begin
						last_r <= 1'b1; // [R10]
					end else if (wr_val[2*i]) begin
						last_r <= 1'b0; // [R10]
					end
					if (ovf) begin
						active_r <= last_r; // [R10]
					end
				end
			end

			assign cmp_val[2*i] = (linked[2*i] && active_r) ?
				val_r[2*i+1] : val_r[2*i]; // [R9] [R12]
			assign cmp_val[2*i+1] = val_r[2*i+1];
		end
	endgenerate

	always_comb begin
		rd_nxt = tcc_pkg::RD_ZERO;
		case (addr)
			tcc_pkg::OFF_CTL:    rd_nxt = {ovf_flag_r, ovf_ie_r, stop_r, 5'h00};
			tcc_pkg::OFF_CNT_HI: rd_nxt = cnt[15:8];
			tcc_pkg::OFF_CNT_LO: rd_nxt = cnt[7:0];
			tcc_pkg::OFF_MOD_HI: rd_nxt = mod_r[15:8];
			tcc_pkg::OFF_MOD_LO: rd_nxt = mod_r[7:0];
			default:             rd_nxt = tcc_pkg::RD_ZERO;
		endcase
		for (int k = 0; k < N; k++) begin
			if (hit_sc[k]) begin
				rd_nxt = sc_r[k];
			end
			if (hit_hi[k]) begin
				rd_nxt = val_r[k][15:8];
			end
			if (hit_lo[k]) begin
				rd_nxt = val_r[k][7:0];
			end
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_r <= tcc_pkg::RD_ZERO;
		end else if (rd) begin
			rdata_r <= rd_nxt;
		end else begin
			rdata_r <= tcc_pkg::RD_ZERO;
		end
	end

	assign rdata        = rdata_r;
	assign chan_pin_out = pin_out_w;
	assign chan_pin_oe  = pin_oe_w;
	assign chan_irq     = irq_r;
	assign ovf_irq      = ovf_irq_r;
endmodule

// ==== tb/tcc_pins_model.sv ====
module tcc_pins_model (
	input  wire logic [3:0]  pin_out,
	input  wire logic [3:0]  pin_oe,
	input  wire logic [3:0]  ext,
	input  wire logic [1:0]  mon,
	input  wire logic        clk,
	output logic      [3:0]  pin_in,
	output logic      [15:0] hi = 16'h0000,
	output logic      [15:0] per = 16'h0000,
	output logic      [7:0]  rises = 8'h00
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        last_r = 1'b0;
	logic [15:0] cyc_r = 16'h0000;
	// A released pin shows the outside source, so a freed upper pin is plain I/O
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
	always_ff @(posedge clk) begin
		last_r <= pin_out[mon];
		cyc_r <= cyc_r + 16'h0001;
		if (pin_out[mon] && !last_r) begin
			per <= cyc_r;
			cyc_r <= 16'h0001;
			rises <= rises + 8'h01;
		end
		if (!pin_out[mon] && last_r)
			hi <= cyc_r;
	end
endmodule

// ==== tb/tcc_top_sva.sv ====
module tcc_top_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic [3:0] chan_pin_in,
	input wire logic [3:0] chan_pin_out,
	input wire logic [3:0] chan_pin_oe,
	input wire logic [3:0] chan_irq,
	input wire logic       ovf_irq
);
	logic [7:0] sc_r [4];
	logic [7:0] ctl_r;
	logic [3:0] ie;
	// Shadow of software writes; enables, modes, edge selects and the overflow toggle bit are needed here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sc_r <= '{default: 8'h00};
			ctl_r <= 8'h00;
		end else if (wr) begin
			for (int i = 0; i < 4; i++)
				if (addr == 6'(6 + 3 * i))
					sc_r[i] <= wdata;
			if (addr == tcc_pkg::OFF_CTL)
				ctl_r <= wdata;
		end
	end
	assign ie = {sc_r[3][6], sc_r[2][6], sc_r[1][6], sc_r[0][6]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_chirq_gated: assert property ((chan_irq & ~$past(ie)) == 4'h0)
		else $error("channel request without enable");
	a_ovf_gated: assert property (ovf_irq |-> $past(ctl_r[6]))
		else $error("overflow request without enable");
	a_link01_free: assert property (sc_r[0][5] && $past(sc_r[0][5]) |-> !chan_pin_oe[1])
		else $error("channel 1 pin driven while linked");
	a_link23_free: assert property (sc_r[2][5] && $past(sc_r[2][5]) |-> !chan_pin_oe[3])
		else $error("channel 3 pin driven while linked");
	a_link0_drive: assert property (sc_r[0][5] && sc_r[0][3:2] != 2'h0
		&& $stable(sc_r[0]) |-> chan_pin_oe[0]) else $error("linked pin 0 not driven");
	a_unbuf_drive: assert property (!sc_r[0][5] && sc_r[1][5:4] == 2'h1
		&& sc_r[1][3:2] != 2'h0 && $stable(sc_r[1]) && $stable(sc_r[0][5]) |-> chan_pin_oe[1])
		else $error("compare pin 1 not driven");
	a_cap_request: assert property (sc_r[1][6:2] == 5'h11 && !sc_r[0][5]
		&& $stable(sc_r[1]) && $rose(chan_pin_in[1]) |-> ##[1:3] chan_irq[1])
		else $error("capture edge gave no request");
	a_set_holds: assert property (!sc_r[2][5] && sc_r[3][4:1] == 4'hE && $stable(sc_r[3])
		&& $stable(sc_r[2][5]) |-> !$fell(chan_pin_out[3])) else $error("set-only pin fell");
endmodule

bind tcc_top tcc_top_chk i_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
	.chan_irq(chan_irq), .ovf_irq(ovf_irq));

// ==== tb/tb_tcc_top.sv ====
module tb_tcc_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  addr = 6'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [3:0]  ext = 4'h0;
	logic [1:0]  mon = 2'h0;
	logic [7:0]  rdata, rv, rises;
	logic [3:0]  pin_in, pin_out, pin_oe, irq;
	logic [15:0] hi, per;
	logic        ovf_irq;
	int          err_total = 0;
	int          checks_done = 0;

	always #2.5 clk = ~clk;

	tcc_top i_tcc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .chan_pin_in(pin_in), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
		.chan_irq(irq), .ovf_irq(ovf_irq));
	tcc_pins_model i_tcc_pins_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .mon(mon),
		.clk(clk), .pin_in(pin_in), .hi(hi), .per(per), .rises(rises));

	function automatic logic [5:0] ch_a(input int i, input logic [5:0] off);
		return tcc_pkg::OFF_CH_BASE + 6'(i) * tcc_pkg::CH_STRIDE + off;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_b(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		wr_b(a, v[15:8]);
		wr_b(a + 6'h01, v[7:0]);
	endtask
	task automatic rd_b(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rd16(input logic [5:0] a, output logic [15:0] v);
		rd_b(a, v[15:8]);
		rd_b(a + 6'h01, v[7:0]);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Waits three rises so the high time comes from a whole period after the write
	task automatic meas(input logic [1:0] ch);
		logic [7:0] r0;
		@(posedge clk);
		mon <= ch;
		tick(1);
		r0 = rises;
		for (int n = 0; n < 1000 && 8'(rises - r0) < 8'd3; n++)
			tick(1);
	endtask
	task automatic t_regs();
		rd_b(tcc_pkg::OFF_MOD_HI, rv);
		chk(16'(rv), 16'h00FF);
		rd_b(6'h3F, rv);
		chk(16'(rv), 16'h0000);
		$display("register test done");
	endtask
	task automatic t_pwm();
		wr16(tcc_pkg::OFF_MOD_HI, 16'h00FF);
		wr16(ch_a(0, tcc_pkg::CH_HI), 16'h0080);
		wr16(ch_a(3, tcc_pkg::CH_HI), 16'h0010);
		wr_b(ch_a(3, tcc_pkg::CH_SC), 8'h1C);
		wr_b(ch_a(1, tcc_pkg::CH_SC), 8'h18);
		wr_b(ch_a(0, tcc_pkg::CH_SC), 8'h1A);
		wr_b(tcc_pkg::OFF_CTL, 8'h50);
		for (int n = 0; n < 300 && ovf_irq !== 1'b1; n++)
			tick(1);
		chk(16'(ovf_irq), 16'h0001);
		wr_b(tcc_pkg::OFF_CTL, 8'h40);
		tick(2);
		chk(16'(ovf_irq), 16'h0000);
		meas(2'h0);
		chk(per, 16'h0100);
		chk(hi, 16'h0081);
		// Shorter width is written just after the compare, as a compare handler would
		@(negedge pin_out[0]);
		wr16(ch_a(0, tcc_pkg::CH_HI), 16'h0040);
		meas(2'h0);
		chk(hi, 16'h0041);
		// Longer width is written just after the overflow toggle
		@(posedge pin_out[0]);
		wr16(ch_a(0, tcc_pkg::CH_HI), 16'h0060);
		meas(2'h0);
		chk(hi, 16'h0061);
		chk(16'(pin_out[3]), 16'h0001);
		$display("pwm test done");
	endtask
	task automatic t_cap();
		logic [15:0] cnt_v;
		logic [15:0] cap_v;
		wr_b(tcc_pkg::OFF_CTL, 8'h20);
		rd16(tcc_pkg::OFF_CNT_HI, cnt_v);
		for (int e = 1; e < 4; e++) begin
			for (int f = 0; f < 2; f++) begin
				wr_b(ch_a(1, tcc_pkg::CH_SC), 8'(8'h40 | (e << 2)));
				tick(4);
				wr_b(ch_a(1, tcc_pkg::CH_SC), 8'(8'h40 | (e << 2)));
				@(posedge clk);
				ext[1] <= (f == 0);
				tick(4);
				chk(16'(irq[1]), 16'(e[f]));
				if (e[f]) begin
					rd16(ch_a(1, tcc_pkg::CH_HI), cap_v);
					chk(cap_v, cnt_v);
				end
			end
		end
		wr_b(ch_a(1, tcc_pkg::CH_SC), 8'h04);
		@(posedge clk);
		ext[1] <= 1'b1;
		tick(4);
		chk(16'(irq[1]), 16'h0000);
		$display("capture test done");
	endtask
	task automatic t_link();
		wr_b(tcc_pkg::OFF_CTL, 8'h00);
		wr_b(ch_a(2, tcc_pkg::CH_SC), 8'h2A);
		wr16(ch_a(2, tcc_pkg::CH_HI), 16'h0020);
		meas(2'h2);
		chk(hi, 16'h0021);
		chk(16'(pin_oe[3]), 16'h0000);
		wr16(ch_a(3, tcc_pkg::CH_HI), 16'h0060);
		meas(2'h2);
		chk(hi, 16'h0061);
		wr16(ch_a(2, tcc_pkg::CH_HI), 16'h0030);
		meas(2'h2);
		chk(hi, 16'h0031);
		// Channel 1 drives its pin first, so linking must visibly release it
		wr_b(ch_a(1, tcc_pkg::CH_SC), 8'h18);
		wr_b(ch_a(0, tcc_pkg::CH_SC), 8'h3A);
		wr16(ch_a(1, tcc_pkg::CH_HI), 16'h0050);
		meas(2'h0);
		chk(hi, 16'h0051);
		chk(16'(pin_oe[1]), 16'h0000);
		$display("link test done");
	endtask
	task automatic close_out();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_pwm();
		t_cap();
		t_link();
		close_out();
	end
	initial begin
		#200us;
		err_total++;
		$display("BAD t=%0t watchdog expired", $time);
		close_out();
	end
endmodule
